/* File: core/bmd_top.sv */
// Summary of operation
// - blanking pixel equal mute pattern enters blackout
// - blackout silences audio and blacks out video
// - data enable active high, select bit inverts
// - data enable always blanking: pattern never checked
`timescale 1ns/10ps
`default_nettype none
`include "bmd_defines.svh"

module bmd_top #(
  parameter int                PIXEL_W       = `BMD_PIXEL_W,
  parameter int                AUDIO_W       = `BMD_AUDIO_W,
  parameter logic [`BMD_RUN_W-1:0] SYNC_ONLY_RUN = `BMD_SYNC_ONLY_RUN
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // configuration
  input  wire logic               data_enable_level_select,
  input  wire logic               blackout_release,
  // recovered video and audio
  input  wire logic [PIXEL_W-1:0] pixel_data_in,
  input  wire logic               active_video_flag_in,
  input  wire logic               hsync_in,
  input  wire logic               vsync_in,
  input  wire logic [AUDIO_W-1:0] audio_data_in,
  // outgoing video and audio
  output logic      [PIXEL_W-1:0] pixel_data_out,
  output logic                    active_video_flag_out,
  output logic                    hsync_out,
  output logic                    vsync_out,
  output logic      [AUDIO_W-1:0] audio_data_out,
  // status
  output logic                    media_blackout_state
);

  // ****************************************
  // data enable level and blanking
  // ****************************************
  wire logic de_active;
  wire logic de_blank;
  assign de_active = active_video_flag_in ^ data_enable_level_select;
  assign de_blank  = ~de_active;

  // ****************************************
  // sync-only detection
  // ****************************************
  // a link whose data enable never goes active carries no mute command;
  // without this guard sync-only timing could match on idle data
  logic [`BMD_RUN_W-1:0] blank_run_reg;
  logic [`BMD_RUN_W-1:0] blank_run_next;
  logic                  de_seen_reg;
  logic                  de_seen_next;
  wire logic             run_full;

  assign run_full       = (blank_run_reg == SYNC_ONLY_RUN);
  assign blank_run_next = de_active ? `BMD_RUN_ZERO
                        : (run_full ? blank_run_reg : blank_run_reg + `BMD_RUN_ONE);
  assign de_seen_next   = de_active | (de_seen_reg & ~run_full);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blank_run_reg <= `BMD_RUN_ZERO;
      de_seen_reg   <= 1'b0;
    end else begin
      blank_run_reg <= blank_run_next;
      de_seen_reg   <= de_seen_next;
    end
  end

  // ****************************************
  // mute pattern compare
  // ****************************************
  wire logic pattern_hit;
  wire logic mute_cmd;
  assign pattern_hit = (pixel_data_in == PIXEL_W'(`BMD_MUTE_PATTERN));
  assign mute_cmd    = pattern_hit & de_blank & de_seen_reg;

  // ****************************************
  // blackout state machine
  // ****************************************
  bmd_pkg::bmd_state_t state_reg;
  bmd_pkg::bmd_state_t state_next;

  // a command in the release cycle wins, so no mute is lost
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bmd_pkg::BMD_ST_PASS: begin
        if (mute_cmd) begin
          state_next = bmd_pkg::BMD_ST_BLACK;
        end
      end
      bmd_pkg::BMD_ST_BLACK: begin
        if (blackout_release && !mute_cmd) begin
          state_next = bmd_pkg::BMD_ST_PASS;
        end
      end
      default: begin
        state_next = bmd_pkg::BMD_ST_BLACK;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bmd_pkg::BMD_ST_PASS;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  // the muting takes effect on the same edge as the state change,
  // so not one pixel after the command leaves unblanked
  wire logic                black_next;
  wire logic [PIXEL_W-1:0]  pixel_next;
  wire logic [AUDIO_W-1:0]  audio_next;
  assign black_next = (state_next == bmd_pkg::BMD_ST_BLACK);
  assign pixel_next = black_next ? PIXEL_W'(`BMD_BLACK_PIXEL) : pixel_data_in;
  assign audio_next = black_next ? AUDIO_W'(`BMD_AUDIO_SILENT) : audio_data_in;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pixel_data_out        <= PIXEL_W'(`BMD_BLACK_PIXEL);
      active_video_flag_out <= 1'b0;
      hsync_out             <= 1'b0;
      vsync_out             <= 1'b0;
      audio_data_out        <= AUDIO_W'(`BMD_AUDIO_SILENT);
      media_blackout_state  <= 1'b0;
    end else begin
      pixel_data_out        <= pixel_next;
      active_video_flag_out <= active_video_flag_in;
      hsync_out             <= hsync_in;
      vsync_out             <= vsync_in;
      audio_data_out        <= audio_next;
      media_blackout_state  <= black_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_enter_on_blank_match;
    @(posedge clock) disable iff (!rst_n)
      (pixel_data_in == PIXEL_W'(`BMD_MUTE_PATTERN)) && de_blank && de_seen_reg
      |=> media_blackout_state;
  endproperty
  a_enter_on_blank_match: assert property (p_enter_on_blank_match)
    else $error("mute pattern in blanking did not enter blackout");

  property p_outputs_muted;
    @(posedge clock) disable iff (!rst_n)
      media_blackout_state |-> (pixel_data_out == PIXEL_W'(`BMD_BLACK_PIXEL))
                               && (audio_data_out == AUDIO_W'(`BMD_AUDIO_SILENT));
  endproperty
  a_outputs_muted: assert property (p_outputs_muted)
    else $error("blackout with live video or audio");

  property p_active_level_no_entry;
    @(posedge clock) disable iff (!rst_n)
      !media_blackout_state && (active_video_flag_in != data_enable_level_select)
      |=> !media_blackout_state;
  endproperty
  a_active_level_no_entry: assert property (p_active_level_no_entry)
    else $error("blackout entered during active video");

  property p_sync_only_no_entry;
    @(posedge clock) disable iff (!rst_n)
      !media_blackout_state && !de_seen_reg |=> !media_blackout_state;
  endproperty
  a_sync_only_no_entry: assert property (p_sync_only_no_entry)
    else $error("blackout entered on sync-only link");

  property p_entry_needs_full_word;
    @(posedge clock) disable iff (!rst_n)
      !media_blackout_state ##1 media_blackout_state
      |-> $past(pixel_data_in) == PIXEL_W'(`BMD_MUTE_PATTERN);
  endproperty
  a_entry_needs_full_word: assert property (p_entry_needs_full_word)
    else $error("blackout entered without full pattern word");

  property p_pass_through;
    @(posedge clock) disable iff (!rst_n)
      !media_blackout_state ##1 !media_blackout_state
      |-> pixel_data_out == $past(pixel_data_in);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("video altered outside blackout");

  property p_blackout_holds;
    @(posedge clock) disable iff (!rst_n)
      media_blackout_state && !blackout_release |=> media_blackout_state;
  endproperty
  a_blackout_holds: assert property (p_blackout_holds)
    else $error("blackout left without release");

  property p_run_end_disarms;
    @(posedge clock) disable iff (!rst_n)
      run_full && de_blank |=> !de_seen_reg;
  endproperty
  a_run_end_disarms: assert property (p_run_end_disarms)
    else $error("sync-only run did not disarm the compare");

  property p_active_rearms;
    @(posedge clock) disable iff (!rst_n)
      de_active |=> de_seen_reg && (blank_run_reg == `BMD_RUN_ZERO);
  endproperty
  a_active_rearms: assert property (p_active_rearms)
    else $error("active cycle did not rearm the compare");

  property p_no_entry_without_word;
    @(posedge clock) disable iff (!rst_n)
      !media_blackout_state && !pattern_hit |=> !media_blackout_state;
  endproperty
  a_no_entry_without_word: assert property (p_no_entry_without_word)
    else $error("blackout entered without mute pattern");

endmodule : bmd_top

`default_nettype wire

/* File: core/bmd_defines.svh */
`ifndef BMD_DEFINES_SVH
`define BMD_DEFINES_SVH

// ****************************************
// pattern and field constants
// ****************************************
`define BMD_PIXEL_W        24
`define BMD_MUTE_PATTERN   24'h666666
`define BMD_BLACK_PIXEL    24'h000000
`define BMD_AUDIO_W        4
`define BMD_AUDIO_SILENT   4'h0
`define BMD_RUN_W          16
`define BMD_RUN_ZERO       16'h0000
`define BMD_RUN_ONE        16'h0001

// ****************************************
// timing
// ****************************************
// blanking run (in pixel cycles) after which the link counts as sync-only
`define BMD_SYNC_ONLY_RUN  16'hFFFF

`endif

/* File: core/bmd_pkg.sv */
package bmd_pkg;

  // ****************************************
  // blackout state machine
  // ****************************************
  typedef enum logic [1:0] {
    BMD_ST_PASS  = 2'b01,
    BMD_ST_BLACK = 2'b10
  } bmd_state_t;

endpackage : bmd_pkg

/* File: bench/bmd_ser_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// serializer far side
// ****
module bmd_ser_model (
  // bench side
  input  wire logic [23:0] pix,
  input  wire logic        act,
  input  wire logic        sel,
  input  wire logic        gate,
  // link side
  output logic      [23:0] pix_out,
  output logic             de_out
);
  assign de_out  = act ^ sel;
  // gated blanking words go out as zero, so no stray match
  assign pix_out = (gate && !act) ? 24'h000000 : pix;
endmodule : bmd_ser_model
`default_nettype wire

/* File: bench/blanking_mute_detector_test.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// blackout detector bench
// ****
module blanking_mute_detector_test;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic        sel       = 1'b0;
  logic        rel       = 1'b0;
  logic        gate      = 1'b0;
  logic        act       = 1'b0;
  logic        hs        = 1'b0;
  logic [23:0] pix       = 24'h000000;
  logic [23:0] lpix;
  logic        lde;
  logic [23:0] pout;
  logic [3:0]  aout;
  logic        mute;
  logic        avf_o;
  logic        hso;
  logic        vso;
  int          bad_count = 0;
  int          compares  = 0;
  always #2.5 clock = ~clock;
  bmd_ser_model ser_u (.pix(pix), .act(act), .sel(sel), .gate(gate),
    .pix_out(lpix), .de_out(lde));
  // short run keeps the sync-only case cheap
  bmd_top #(.SYNC_ONLY_RUN(16'h0010)) dut_u (.clock(clock), .rst_n(rst_n),
    .data_enable_level_select(sel), .blackout_release(rel), .pixel_data_in(lpix),
    .active_video_flag_in(lde), .hsync_in(hs), .vsync_in(~hs), .audio_data_in(4'hA),
    .pixel_data_out(pout), .active_video_flag_out(avf_o), .hsync_out(hso), .vsync_out(vso),
    .audio_data_out(aout), .media_blackout_state(mute));
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic drive(input logic [23:0] p, input logic a, input logic r);
    @(posedge clock);
    pix <= p;
    act <= a;
    rel <= r;
    hs  <= ~hs;
  endtask : drive
  // pattern in blanking, look one edge later, then release
  task automatic cmd(input logic exp);
    drive(24'h666666, 1'b0, 1'b0);
    drive(24'h000000, 1'b1, 1'b0);
    #1 check("mute", {23'h000000, mute}, {23'h000000, exp});
    drive(24'h000000, 1'b1, 1'b1);
  endtask : cmd
  task automatic t_mute;
    drive(24'h123456, 1'b1, 1'b0);
    drive(24'h666666, 1'b0, 1'b0);
    #1 check("pass", pout, 24'h123456);
    check("audio pass", {20'h00000, aout}, 24'h00000A);
    check("active flag", {23'h000000, avf_o}, 24'h000001);
    drive(24'h654321, 1'b1, 1'b0);
    #1 check("mute", {23'h000000, mute}, 24'h000001);
    check("black", pout, 24'h000000);
    check("audio", {20'h00000, aout}, 24'h000000);
    check("blank flag", {23'h000000, avf_o}, 24'h000000);
    check("syncs", {22'h00000, hso, vso}, {22'h00000, ~hs, hs});
    drive(24'h654321, 1'b0, 1'b1);
    drive(24'h111111, 1'b0, 1'b0);
    #1 check("release", {23'h000000, mute}, 24'h000000);
  endtask : t_mute
  task automatic t_ignore;
    drive(24'h666666, 1'b1, 1'b0);
    drive(24'h666667, 1'b0, 1'b0);
    drive(24'h000000, 1'b1, 1'b0);
    #1 check("near", {23'h000000, mute}, 24'h000000);
  endtask : t_ignore
  task automatic t_pol;
    @(posedge clock) sel <= 1'b1;
    drive(24'h000000, 1'b1, 1'b0);
    cmd(1'b1);
    @(posedge clock) sel <= 1'b0;
  endtask : t_pol
  task automatic t_sync;
    drive(24'h000000, 1'b1, 1'b0);
    repeat (20) drive(24'h000000, 1'b0, 1'b0);
    cmd(1'b0);
    cmd(1'b1);
  endtask : t_sync
  task automatic t_gate;
    @(posedge clock) gate <= 1'b1;
    drive(24'h000000, 1'b1, 1'b0);
    cmd(1'b0);
    @(posedge clock) gate <= 1'b0;
  endtask : t_gate
  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_mute();
    t_ignore();
    t_pol();
    t_sync();
    t_gate();
    close_out();
  end
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule : blanking_mute_detector_test
`default_nettype wire
